// ### src/ebrh_ctrl.sv
// external bus cycle sequencer with ready wait states and hold arbitration
//
// Overview of operation
// - ready high at sample adds wait state
// - ready low at sample ends cycle
// - programmed waits first, then ready waits
// - command delay setting postpones command start
// - multiplexed mode adds mux and optional tristate
// - gap two periods mux+tristate, zero demux without tristate
// - asynchronous ready gets internal extra synchroniser
// - finish running cycle before granting hold
// - release: chip selects undriven, others floated
// - bus request only after release completed
// - regain starts only when hold returns high
// - own cycles resume after regain completes
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
module ebrh_ctrl (
	input  wire logic                           clock,
	input  wire logic                           rst_b,
	input  wire logic [3:0]                     reg_addr,
	input  wire logic [ebrh_pkg::EBRH_DATA_W-1:0] reg_wdata,
	input  wire logic                           reg_write,
	input  wire logic                           reg_read,
	output logic      [ebrh_pkg::EBRH_DATA_W-1:0] reg_rdata,
	input  wire logic                           cycle_start,
	input  wire logic                           cycle_write,
	input  wire logic [ebrh_pkg::EBRH_CS_W-1:0] cycle_select,
	output logic                                cycle_busy,
	output logic                                cycle_done,
	output logic                                cpu_clock_pin,
	input  wire logic                           ready_b_pin,
	input  wire logic                           hold_b_pin,
	output logic                                hold_ack,
	output logic                                bus_request_out_b,
	output logic                                ale,
	output logic                                read_strobe_b,
	output logic                                write_strobe_b,
	output logic                                bus_oe,
	output logic      [ebrh_pkg::EBRH_CS_W-1:0] chip_select_lines_b,
	output logic      [ebrh_pkg::EBRH_CS_W-1:0] chip_select_lines_oe
);
	import ebrh_pkg::*;

	// ----------------------------------------------------------------
	// reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic                      rst_meta;
	logic                      rst_sync_b;
	logic                      ready_meta;
	logic                      ready_sync;
	logic                      ready_async;
	logic                      hold_meta;
	logic                      hold_sync;
	logic                      ready_seen_b;
	logic                      tick;
	logic [EBRH_CFG_W-1:0]     config_reg;
	logic [15:0]               rdy_count;
	logic [EBRH_CFG_WAIT_W-1:0] wait_left;
	logic                      pending;
	logic                      pending_write;
	logic [EBRH_CS_W-1:0]      pending_select;
	logic [EBRH_CS_W-1:0]      active_select;
	logic                      active_write;
	logic                      held_settled;
	logic                      hold_req;
	ebrh_state_type            state;
	ebrh_state_type            next_state;
	ebrh_state_type            after_cycle;
	logic                      cycle_end;

	// ----------------------------------------------------------------
	// shared decodes
	// ----------------------------------------------------------------
	// ready sampling point: command phase with no programmed wait left
	function automatic logic ebrh_at_sample(input ebrh_state_type st,
		input logic [EBRH_CFG_WAIT_W-1:0] left);
		return st == EBRH_CMD && left == '0;
	endfunction : ebrh_at_sample

	// command strobe level for the coming pin period, active low
	function automatic logic ebrh_cmd_b(input ebrh_state_type nxt, input logic ended,
		input logic is_write, input logic want_write);
		return !(nxt == EBRH_CMD && is_write == want_write && !ended);
	endfunction : ebrh_cmd_b

	// pins are driven in every state but the released one
	function automatic logic ebrh_drives(input ebrh_state_type nxt);
		return nxt != EBRH_HELD;
	endfunction : ebrh_drives

	// two-stage reset release
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta   <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_b <= rst_meta;
		end
	end

	// ready and hold pins enter through two flip-flops
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ready_meta <= 1'b1;
			ready_sync <= 1'b1;
			hold_meta  <= 1'b1;
			hold_sync  <= 1'b1;
		end else begin
			ready_meta <= ready_b_pin;
			ready_sync <= ready_meta;
			hold_meta  <= hold_b_pin;
			hold_sync  <= hold_meta;
		end
	end

	// extra stage for the asynchronous ready form
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ready_async <= 1'b1;
		end else begin
			ready_async <= ready_sync;
		end
	end

	// async form reads the third stage
	assign ready_seen_b = config_reg[EBRH_CFG_ASYNC_RDY] ? ready_async : ready_sync;
	assign hold_req     = !hold_sync && config_reg[EBRH_CFG_HOLD_EN];

	// ----------------------------------------------------------------
	// pin clock divider
	// ----------------------------------------------------------------
	// the sequencer steps on the edge where the pin clock rises
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cpu_clock_pin <= 1'b0;
		end else begin
			cpu_clock_pin <= !cpu_clock_pin;
		end
	end

	// one tick per pin period, on the edge where the pin clock rises
	assign tick = !cpu_clock_pin;

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	// configuration written by software
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			config_reg <= EBRH_CFG_RESET;
		end else if (reg_write && reg_addr == EBRH_ADDR_CONFIG) begin
			config_reg <= reg_wdata[EBRH_CFG_W-1:0];
		end
	end

	// read data stand for one cycle only
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= '0;
		end else if (reg_read) begin
			unique case (reg_addr)
				EBRH_ADDR_CONFIG:    reg_rdata <= {{(EBRH_DATA_W-EBRH_CFG_W){1'b0}}, config_reg};
				EBRH_ADDR_STATUS:    reg_rdata <= {11'h000, pending, !bus_request_out_b,
					hold_ack, !bus_oe, cycle_busy};
				EBRH_ADDR_RDY_COUNT: reg_rdata <= rdy_count;
				default:             reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ----------------------------------------------------------------
	// cycle request capture
	// ----------------------------------------------------------------
	// a new request is taken only while none is pending; one arriving before the clear is dropped
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pending        <= 1'b0;
			pending_write  <= 1'b0;
			pending_select <= '0;
		end else if (cycle_start && !pending) begin
			pending        <= 1'b1;
			pending_write  <= cycle_write;
			pending_select <= cycle_select;
		end else if (tick && next_state == EBRH_ADDR) begin
			pending        <= 1'b0;
		end
	end

	// busy also covers the one regain pin period
	assign cycle_busy = pending || (state != EBRH_IDLE && state != EBRH_HELD);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// the command period after the last programmed wait is the ready sampling point
	assign cycle_end = ebrh_at_sample(state, wait_left) && !ready_seen_b;

	// what follows a finished cycle, or an idle point
	always_comb begin
		if (hold_req) begin
			after_cycle = EBRH_HELD;
		end else if (pending) begin
			after_cycle = EBRH_ADDR;
		end else begin
			after_cycle = EBRH_IDLE;
		end
	end

	// next state on each pin clock rise
	always_comb begin
		next_state = state;
		unique case (state)
			EBRH_IDLE: begin
				next_state = after_cycle;
			end
			EBRH_ADDR: begin
				next_state = config_reg[EBRH_CFG_CMD_DELAY] ? EBRH_DELAY : EBRH_CMD;
			end
			EBRH_DELAY: begin
				next_state = EBRH_CMD;
			end
			EBRH_CMD: begin
				if (cycle_end) begin
					if (config_reg[EBRH_CFG_MUX]) begin
						next_state = EBRH_MUXW;
					end else if (config_reg[EBRH_CFG_TRISTATE]) begin
						next_state = EBRH_TRIW;
					end else begin
						next_state = after_cycle;
					end
				end
			end
			EBRH_MUXW: begin
				next_state = config_reg[EBRH_CFG_TRISTATE] ? EBRH_TRIW : after_cycle;
			end
			EBRH_TRIW: begin
				next_state = after_cycle;
			end
			EBRH_HELD: begin
				if (!hold_req) begin
					next_state = EBRH_REGAIN;
				end
			end
			EBRH_REGAIN: begin
				next_state = hold_req ? EBRH_HELD : (pending ? EBRH_ADDR : EBRH_IDLE);
			end
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state <= EBRH_IDLE;
		end else if (tick) begin
			state <= next_state;
		end
	end

	// programmed wait counter and cycle attributes
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			wait_left     <= '0;
			active_write  <= 1'b0;
			active_select <= '0;
		end else if (tick) begin
			if (next_state == EBRH_ADDR) begin
				active_write  <= pending_write;
				active_select <= pending_select;
			end
			if (state != EBRH_CMD && next_state == EBRH_CMD) begin
				wait_left <= config_reg[EBRH_CFG_WAIT_LSB +: EBRH_CFG_WAIT_W];
			end else if (state == EBRH_CMD && wait_left != '0) begin
				wait_left <= wait_left - 1'b1;
			end
		end
	end

	// count ready-controlled wait states
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rdy_count <= EBRH_RDY_COUNT_RESET;
		end else if (reg_write && reg_addr == EBRH_ADDR_RDY_COUNT) begin
			rdy_count <= EBRH_RDY_COUNT_RESET;
		end else if (tick && ebrh_at_sample(state, wait_left) && ready_seen_b) begin
			rdy_count <= rdy_count + 16'h0001;
		end
	end

	// completion pulse for the user side
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cycle_done <= 1'b0;
		end else begin
			cycle_done <= tick && cycle_end;
		end
	end

	// ----------------------------------------------------------------
	// bus pins
	// ----------------------------------------------------------------
	// strobes, address latch and drive enables
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ale                  <= 1'b0;
			read_strobe_b        <= 1'b1;
			write_strobe_b       <= 1'b1;
			bus_oe               <= 1'b1;
			chip_select_lines_b  <= {EBRH_CS_W{1'b1}};
			chip_select_lines_oe <= {EBRH_CS_W{1'b1}};
		end else if (tick) begin
			ale            <= next_state == EBRH_ADDR;
			read_strobe_b  <= ebrh_cmd_b(next_state, cycle_end, active_write, 1'b0);
			write_strobe_b <= ebrh_cmd_b(next_state, cycle_end, active_write, 1'b1);
			if (next_state == EBRH_ADDR) begin
				chip_select_lines_b <= ~pending_select;
			end else if (next_state != EBRH_DELAY && next_state != EBRH_CMD) begin
				chip_select_lines_b <= {EBRH_CS_W{1'b1}};
			end
			bus_oe               <= ebrh_drives(next_state);
			chip_select_lines_oe <= {EBRH_CS_W{ebrh_drives(next_state)}};
		end
	end

	// hold acknowledge and own bus request
	always_ff @(posedge clock or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			hold_ack          <= 1'b0;
			held_settled      <= 1'b0;
			bus_request_out_b <= 1'b1;
		end else if (tick) begin
			hold_ack     <= !ebrh_drives(next_state);
			held_settled <= state == EBRH_HELD && next_state == EBRH_HELD;
			// own request only once the release has settled for a pin period
			bus_request_out_b <= !(held_settled && next_state == EBRH_HELD && pending);
		end
	end

endmodule : ebrh_ctrl

// ### src/ebrh_pkg.sv
// constants, register map and state codes of the external bus controller
package ebrh_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  EBRH_ADDR_CONFIG     = 4'h0;
	localparam logic [3:0]  EBRH_ADDR_STATUS     = 4'h1;
	localparam logic [3:0]  EBRH_ADDR_RDY_COUNT  = 4'h2;

	// config field positions
	localparam int          EBRH_CFG_WAIT_LSB    = 0;
	localparam int          EBRH_CFG_WAIT_W      = 4;
	localparam int          EBRH_CFG_CMD_DELAY   = 4;
	localparam int          EBRH_CFG_MUX         = 5;
	localparam int          EBRH_CFG_TRISTATE    = 6;
	localparam int          EBRH_CFG_ASYNC_RDY   = 7;
	localparam int          EBRH_CFG_HOLD_EN     = 8;
	localparam int          EBRH_CFG_W           = 9;
	localparam logic [8:0]  EBRH_CFG_RESET       = 9'h000;

	// status field positions
	localparam int          EBRH_ST_BUSY         = 0;
	localparam int          EBRH_ST_RELEASED     = 1;
	localparam int          EBRH_ST_HOLD_ACK     = 2;
	localparam int          EBRH_ST_BUS_REQ      = 3;
	localparam int          EBRH_ST_PENDING      = 4;

	// ----------------------------------------------------------------
	// widths and timing
	// ----------------------------------------------------------------
	localparam int          EBRH_DATA_W          = 16;
	localparam int          EBRH_CS_W            = 4;
	localparam int          EBRH_CLOCK_MHZ       = 50;
	localparam int          EBRH_PIN_PERIOD_NS   = 40;
	localparam int          EBRH_PIN_PERIOD_CYC  = EBRH_PIN_PERIOD_NS * EBRH_CLOCK_MHZ / 1000;
	localparam logic [15:0] EBRH_RDY_COUNT_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// bus sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		EBRH_IDLE,
		EBRH_ADDR,
		EBRH_DELAY,
		EBRH_CMD,
		EBRH_MUXW,
		EBRH_TRIW,
		EBRH_HELD,
		EBRH_REGAIN
	} ebrh_state_type;

endpackage : ebrh_pkg

// ### verification/ebrh_ctrl_chk.sv
// port checker for the external bus controller
`timescale 1ns/1ps
module ebrh_ctrl_chk (
	input wire logic                          clock,
	input wire logic                          rst_b,
	input wire logic                          cpu_clock_pin,
	input wire logic                          ready_b_pin,
	input wire logic                          hold_b_pin,
	input wire logic                          cycle_done,
	input wire logic                          hold_ack,
	input wire logic                          bus_request_out_b,
	input wire logic                          ale,
	input wire logic                          read_strobe_b,
	input wire logic                          write_strobe_b,
	input wire logic                          bus_oe,
	input wire logic [ebrh_pkg::EBRH_CS_W-1:0] chip_select_lines_oe
);
	import ebrh_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	logic [3:0] rdy_age;
	logic [3:0] hold_age;
	// edges since ready and hold were last seen low
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rdy_age <= 4'hF;
			hold_age <= 4'hF;
		end else begin
			rdy_age <= !ready_b_pin ? 4'h0 : rdy_age + {3'h0, rdy_age != 4'hF};
			hold_age <= !hold_b_pin ? 4'h0 : hold_age + {3'h0, hold_age != 4'hF};
		end
	end
	property p_done_ready;
		cycle_done |-> rdy_age < 4'hA;
	endproperty
	a_done_ready: assert property (p_done_ready) else $error("end without ready");
	property p_done_end;
		$rose(cycle_done) |-> ##[0:2] (read_strobe_b && write_strobe_b);
	endproperty
	a_done_end: assert property (p_done_end) else $error("command outlives end");
	property p_done_pulse;
		cycle_done |=> !cycle_done;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_release;
		hold_ack |-> !bus_oe && chip_select_lines_oe == '0;
	endproperty
	a_release: assert property (p_release) else $error("bus driven while held");
	property p_no_cycle;
		hold_ack |-> read_strobe_b && write_strobe_b && !ale;
	endproperty
	a_no_cycle: assert property (p_no_cycle) else $error("cycle while held");
	property p_bus_request_out;
		$fell(bus_request_out_b) |-> hold_ack && $past(hold_ack);
	endproperty
	a_bus_request_out: assert property (p_bus_request_out) else $error("early bus request");
	property p_regain;
		$fell(hold_ack) |-> $past(hold_b_pin) && $past(hold_b_pin, 2);
	endproperty
	a_regain: assert property (p_regain) else $error("regain without hold high");
	property p_grant;
		$rose(hold_ack) |-> hold_age < 4'hA && bus_request_out_b;
	endproperty
	a_grant: assert property (p_grant) else $error("grant without hold");
	property p_drive_back;
		$fell(hold_ack) |-> bus_oe && bus_request_out_b;
	endproperty
	a_drive_back: assert property (p_drive_back) else $error("regain not driven");
	property p_pin_clock;
		$rose(cpu_clock_pin) |=> !cpu_clock_pin ##1 cpu_clock_pin;
	endproperty
	a_pin_clock: assert property (p_pin_clock) else $error("pin clock period wrong");
	c_done: cover property (cycle_done);
	c_grant: cover property ($rose(hold_ack));
	c_bus_request_out: cover property ($fell(bus_request_out_b));
endmodule : ebrh_ctrl_chk

bind ebrh_ctrl ebrh_ctrl_chk u_ebrh_ctrl_chk (.clock(clock), .rst_b(rst_b),
	.cpu_clock_pin(cpu_clock_pin),
	.ready_b_pin(ready_b_pin), .hold_b_pin(hold_b_pin), .cycle_done(cycle_done),
	.hold_ack(hold_ack), .bus_request_out_b(bus_request_out_b), .ale(ale),
	.read_strobe_b(read_strobe_b), .write_strobe_b(write_strobe_b), .bus_oe(bus_oe),
	.chip_select_lines_oe(chip_select_lines_oe));

// ### verification/ebrh_ctrl_tb.sv
// self-checking bench for the external bus controller
`timescale 1ns/1ps
module ebrh_ctrl_tb;
	import ebrh_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic cycle_start = 1'b0;
	logic cycle_write = 1'b0;
	logic [3:0] cycle_select = 4'h1;
	logic hold_b_pin = 1'b1;
	logic [3:0] ready_delay = 4'h0;
	logic [15:0] reg_rdata;
	logic cycle_busy, cycle_done, cpu_clock_pin, ready_b_pin, hold_ack, bus_request_out_b;
	logic ale, read_strobe_b, write_strobe_b, bus_oe;
	logic [3:0] cs_b, cs_oe, cs_wire, w, d;
	int error_cnt = 0, samples_checked = 0, cyc = 0, low = 0, seed, i;
	int t_fall, t_rise, last_cmd, last_gap, tcmd[16], gap[16], min_q[$];
	logic [15:0] rd_q[$];
	logic wr_q[$];
	logic [3:0] sel_q[$];
	logic rd_d = 1'b0, idle_d = 1'b1, ale_d = 1'b0, wr_seen = 1'b0;
	wire [4:0] obs = {ale, bus_request_out_b, hold_ack, cycle_done, read_strobe_b & write_strobe_b};
	always #10 clock = ~clock;
	ebrh_ctrl u_ebrh_ctrl (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.cycle_start(cycle_start), .cycle_write(cycle_write), .cycle_select(cycle_select),
		.cycle_busy(cycle_busy), .cycle_done(cycle_done), .cpu_clock_pin(cpu_clock_pin),
		.ready_b_pin(ready_b_pin), .hold_b_pin(hold_b_pin), .hold_ack(hold_ack),
		.bus_request_out_b(bus_request_out_b), .ale(ale), .read_strobe_b(read_strobe_b),
		.write_strobe_b(write_strobe_b), .bus_oe(bus_oe), .chip_select_lines_b(cs_b),
		.chip_select_lines_oe(cs_oe));
	ebrh_far_side u_ebrh_far_side (.clock(clock), .cpu_clock_pin(cpu_clock_pin),
		.read_strobe_b(read_strobe_b), .write_strobe_b(write_strobe_b),
		.ready_delay(ready_delay), .cs_b(cs_b), .cs_oe(cs_oe), .ready_b_pin(ready_b_pin),
		.cs_wire(cs_wire));
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (exp !== got) begin
			error_cnt++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		rd_q.push_back(e);
		@(posedge clock);
		reg_read <= 1'b0;
	endtask : rd
	// one cycle request; mn is the least strobe low time in pin periods
	task automatic go(input logic [3:0] mn);
		@(posedge clock);
		cycle_start <= 1'b1;
		cycle_write <= 1'($random(seed));
		cycle_select <= 4'h1 << 2'($random(seed));
		@(posedge clock);
		cycle_start <= 1'b0;
		wr_q.push_back(cycle_write);
		sel_q.push_back(~cycle_select);
		min_q.push_back(2 * mn);
	endtask : go
	task automatic wait_bit(input int k, input logic v);
		int n;
		n = 0;
		while (obs[k] !== v) begin
			@(negedge clock);
			n++;
			if (n > 3000) begin
				error_cnt++;
				$display("[ERR] wait %0d exp %b got %b", k, v, obs[k]);
				stop_test();
			end
		end
	endtask : wait_bit
	// result watcher: read data and cycle ends against the noted values
	always @(negedge clock) begin
		cyc++;
		if (rd_d)
			chk("reg_rdata", rd_q.pop_front(), reg_rdata);
		rd_d = reg_read;
		if (!obs[0])
			low++;
		if (!write_strobe_b)
			wr_seen = 1'b1;
		if (cycle_done) begin
			chk("strobe kind", {15'h0, wr_q.pop_front()}, {15'h0, wr_seen});
			chk("strobe low", 16'h1, {15'h0, low >= min_q.pop_front()});
			low = 0;
			wr_seen = 1'b0;
		end
		if (ale_d && !ale)
			t_fall = cyc;
		if (idle_d && !obs[0]) begin
			last_cmd = cyc - t_fall;
			chk("cs select", {12'h0, sel_q.pop_front()}, {12'h0, cs_wire});
		end
		if (!idle_d && obs[0])
			t_rise = cyc;
		if (!ale_d && ale)
			last_gap = cyc - t_rise;
		idle_d = obs[0];
		ale_d = ale;
	end
	initial begin
		seed = 32'h8673;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		// reset values and an unmapped place
		wr(4'hF, 16'hFFFF);
		rd(EBRH_ADDR_CONFIG, 16'(EBRH_CFG_RESET));
		rd(EBRH_ADDR_STATUS, 16'h0000);
		rd(EBRH_ADDR_RDY_COUNT, EBRH_RDY_COUNT_RESET);
		rd(4'hF, 16'h0000);
		// every mode mix, two back-to-back cycles each
		for (i = 0; i < 16; i++) begin
			w = 4'($random(seed) & 3);
			d = 4'($random(seed) & 3);
			ready_delay <= d;
			wr(EBRH_ADDR_CONFIG, {8'h00, i[3:0], w});
			wr(EBRH_ADDR_RDY_COUNT, 16'($random(seed)));
			go(w > d ? w : d);
			wait_bit(4, 1'b1);
			go(w > d ? w : d);
			wait_bit(1, 1'b1);
			tcmd[i] = last_cmd;
			@(negedge clock);
			wait_bit(1, 1'b1);
			gap[i] = last_gap;
			if (w >= d + 2)
				rd(EBRH_ADDR_RDY_COUNT, 16'h0000);
		end
		for (i = 0; i < 16; i += 2) begin
			chk("cmd delay", 16'h1, {15'h0, tcmd[i+1] > tcmd[i]});
			if (i[2:1] == 2'b00) begin
				chk("demux gap", 16'h0000, 16'(gap[i]));
				chk("mux gap", 16'(EBRH_PIN_PERIOD_CYC), 16'(gap[i|2] - gap[i]));
				chk("tri gap", 16'(2 * EBRH_PIN_PERIOD_CYC), 16'(gap[i|6] - gap[i]));
			end
		end
		// ready waits counted in the synchronous, then the asynchronous form
		ready_delay <= 4'h3;
		for (i = 0; i < 2; i++) begin
			wr(EBRH_ADDR_CONFIG, {8'h00, i[0], 7'h00});
			wr(EBRH_ADDR_RDY_COUNT, 16'h0000);
			go(4'h3);
			wait_bit(1, 1'b1);
			rd(EBRH_ADDR_RDY_COUNT, 16'(3 + i));
		end
		// hold in mid-cycle, own request waits while released
		ready_delay <= 4'h2;
		wr(EBRH_ADDR_CONFIG, 16'h0100);
		go(4'h2);
		wait_bit(0, 1'b0);
		@(posedge clock);
		hold_b_pin <= 1'b0;
		wait_bit(1, 1'b1);
		wait_bit(2, 1'b1);
		chk("cs wire", 16'h000F, {12'h0, cs_wire});
		chk("bus oe", 16'h0000, {15'h0, bus_oe});
		go(4'h0);
		wait_bit(3, 1'b0);
		repeat (8) @(negedge clock);
		chk("still held", 16'h1, {15'h0, hold_ack & obs[0]});
		@(posedge clock);
		hold_b_pin <= 1'b1;
		wait_bit(2, 1'b0);
		wait_bit(1, 1'b1);
		// hold dropped with no own request
		@(posedge clock);
		hold_b_pin <= 1'b0;
		wait_bit(2, 1'b1);
		rd(EBRH_ADDR_STATUS, 16'h0006);
		hold_b_pin <= 1'b1;
		wait_bit(2, 1'b0);
		repeat (2) @(negedge clock);
		chk("regained", 16'h1, {15'h0, bus_request_out_b & bus_oe & !cycle_busy});
		stop_test();
	end
endmodule : ebrh_ctrl_tb

// ### verification/ebrh_far_side.sv
// far side model: ready responder and pulled-up chip select wires
`timescale 1ns/1ps
module ebrh_far_side (
	input wire logic                          clock,
	input wire logic                          cpu_clock_pin,
	input wire logic                          read_strobe_b,
	input wire logic                          write_strobe_b,
	input wire logic [3:0]                    ready_delay,
	input wire logic [ebrh_pkg::EBRH_CS_W-1:0] cs_b,
	input wire logic [ebrh_pkg::EBRH_CS_W-1:0] cs_oe,
	output logic                              ready_b_pin,
	output logic     [ebrh_pkg::EBRH_CS_W-1:0] cs_wire
);
	import ebrh_pkg::*;
	logic [3:0] ticks;
	logic       pin_q;
	// pin clock rises counted while a command is low
	always_ff @(posedge clock) begin
		pin_q <= cpu_clock_pin;
		if (read_strobe_b && write_strobe_b)
			ticks <= 4'h0;
		else if (cpu_clock_pin && !pin_q && ticks != 4'hF)
			ticks <= ticks + 4'h1;
	end
	// ready low after the delay, held until the command ends
	assign ready_b_pin = (read_strobe_b && write_strobe_b) || ticks < ready_delay;
	// released selects go up to the pull-up level
	assign cs_wire = cs_b | ~cs_oe;
endmodule : ebrh_far_side
